// ===== rtl/dasq_top.sv
// Converter sequencing block: A/D start and stop timing plus D/A output amplifier enable sequence.
// Assumes a classic Wishbone master, synchronous active-high reset and a single 100 MHz clock.
`include "dasq_consts.svh"
`default_nettype none

module dasq_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic adc_analog_run_o,
    output logic amp_on_o,
    output logic amp_switch_o,
    output logic dac_out_en_o,
    output logic [11:0] dac_value_o
);
    import dasq_pkg::*;

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    logic conversion_start_bit; // Software start request for the A/D
    logic interference_guard_enable; // Guard between D/A and A/D activity
    logic shared_converter_enable; // Both D/A channels enabled together
    logic chan0_converter_enable; // Channel 0 converter enable
    logic chan0_output_enable; // Channel 0 output pin enable
    logic chan0_amp_switch; // Amplifier bypass switch
    logic chan0_amp_enable; // Amplifier power enable
    logic [11:0] chan0_data_preload; // Value loaded before amplifier start
    logic [11:0] chan0_conversion_value; // Value actually converted
    logic [7:0] clk_div; // Converter clock divider setting
    logic adc1_module_stop; // Module stop request for A/D unit 1
    logic event_link_drive; // Event link owns D/A operation
    logic dac_halted; // Sticky: D/A halted by a forbidden stop
    logic [7:0] div_cnt; // Divider counter
    logic converter_clock; // One-cycle enable at converter rate
    logic [2:0] adc_cnt; // Converter clocks spent in a transition
    dasq_adc_e adc_state; // A/D analog unit state
    dasq_amp_e amp_state; // Output amplifier state
    logic [15:0] settle_cnt; // Settling time counter
    logic bus_req; // Valid bus request this cycle
    logic wr_req; // Write request
    logic out_req; // Output request from either enable

    // Byte-lane write merge for one 32-bit word
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v, input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Address match for a write request
    function automatic logic wr_hit(input logic [7:0] adr, input logic [7:0] ofs, input logic req);
        return req && (adr == ofs);
    endfunction

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_req = bus_req && wb_we_i;
    assign out_req = shared_converter_enable || chan0_output_enable;

    // ------------------------------------------------------------------------
    // Bus acknowledge: one wait state, answer the cycle after the strobe
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // ------------------------------------------------------------------------
    // A/D and guard control registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conversion_start_bit <= 1'b0;
            interference_guard_enable <= 1'b0;
            clk_div <= `DASQ_DIV_RESET;
            adc1_module_stop <= 1'b0;
            event_link_drive <= 1'b0;
        end else begin
            if (wr_hit(wb_adr_i, `DASQ_ADC_CONTROL_STATUS_OFS, wr_req) && wb_sel_i[0]) begin
                conversion_start_bit <= wb_dat_i[`DASQ_CONV_START_BIT];
            end
            if (wr_hit(wb_adr_i, `DASQ_INTERFERENCE_GUARD_CONTROL_OFS, wr_req) && wb_sel_i[0]) begin
                interference_guard_enable <= wb_dat_i[`DASQ_GUARD_ENABLE_BIT];
            end
            if (wr_hit(wb_adr_i, `DASQ_CONVERTER_CLOCK_DIV_OFS, wr_req)) begin
                clk_div <= 8'(merge({24'h000000, clk_div}, wb_dat_i, wb_sel_i));
            end
            if (wr_hit(wb_adr_i, `DASQ_MODULE_CONTROL_OFS, wr_req) && wb_sel_i[0]) begin
                adc1_module_stop <= wb_dat_i[`DASQ_ADC1_STOP_BIT];
                event_link_drive <= wb_dat_i[`DASQ_EVENT_LINK_BIT];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Sticky D/A halt: stopping A/D unit 1 under the guard also halts the D/A.
    // Only a write with the halted bit set clears it, and a unit 1 stop under the guard in that cycle still wins.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac_halted <= 1'b0;
        end else if (adc1_module_stop && interference_guard_enable) begin
            dac_halted <= 1'b1;
        end else if (wr_hit(wb_adr_i, `DASQ_MODULE_CONTROL_OFS, wr_req) && wb_sel_i[0] &&
                     wb_dat_i[`DASQ_DAC_HALTED_BIT]) begin
            dac_halted <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // D/A control, amplifier switch bits and data registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shared_converter_enable <= 1'b0;
            chan0_converter_enable <= 1'b0;
            chan0_output_enable <= 1'b0;
            chan0_amp_switch <= 1'b0;
            chan0_amp_enable <= 1'b0;
            chan0_data_preload <= `DASQ_DATA_RESET;
            chan0_conversion_value <= `DASQ_DATA_RESET;
        end else begin
            if (wr_hit(wb_adr_i, `DASQ_DAC_CONTROL_OFS, wr_req) && wb_sel_i[0]) begin
                shared_converter_enable <= wb_dat_i[`DASQ_SHARED_ENABLE_BIT];
                chan0_converter_enable <= wb_dat_i[`DASQ_CHAN0_ENABLE_BIT];
                chan0_output_enable <= wb_dat_i[`DASQ_CHAN0_OUT_ENABLE_BIT];
            end
            // Switch bits change only on a write to their own register
            if (wr_hit(wb_adr_i, `DASQ_AMP_SWITCH_CONTROL_OFS, wr_req) && wb_sel_i[0]) begin
                chan0_amp_switch <= wb_dat_i[`DASQ_CHAN0_AMP_SWITCH_BIT];
                chan0_amp_enable <= wb_dat_i[`DASQ_CHAN0_AMP_ENABLE_BIT];
            end
            if (wr_hit(wb_adr_i, `DASQ_CHAN0_DATA_PRELOAD_OFS, wr_req)) begin
                chan0_data_preload <= 12'(merge({20'h00000, chan0_data_preload}, wb_dat_i, wb_sel_i));
            end
            if (wr_hit(wb_adr_i, `DASQ_CHAN0_CONVERSION_VALUE_OFS, wr_req)) begin
                chan0_conversion_value <= 12'(merge({20'h00000, chan0_conversion_value}, wb_dat_i, wb_sel_i));
            end
        end
    end

    // ------------------------------------------------------------------------
    // Converter clock enable divider
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= 8'h00;
            converter_clock <= 1'b0;
        end else if (div_cnt >= clk_div) begin
            div_cnt <= 8'h00;
            converter_clock <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 8'h01;
            converter_clock <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // A/D analog unit sequencing. Transitions complete on the last allowed
    // converter clock; a faster finish would still meet the bound but this
    // keeps the timing deterministic for software.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_state <= DASQ_ADC_IDLE;
            adc_cnt <= 3'h0;
        end else begin
            case (adc_state)
                DASQ_ADC_IDLE: begin
                    adc_cnt <= 3'h0;
                    if (conversion_start_bit && !adc1_module_stop) begin
                        adc_state <= DASQ_ADC_START;
                    end
                end
                DASQ_ADC_START: begin
                    if (!conversion_start_bit) begin
                        adc_state <= DASQ_ADC_IDLE;
                    end else if (converter_clock) begin
                        adc_cnt <= adc_cnt + 3'h1;
                        if (adc_cnt == 3'(`DASQ_RESTART_MAX_CYC - 1)) begin
                            adc_state <= DASQ_ADC_RUN;
                        end
                    end
                end
                DASQ_ADC_RUN: begin
                    adc_cnt <= 3'h0;
                    if (!conversion_start_bit || adc1_module_stop) begin
                        adc_state <= DASQ_ADC_STOP;
                    end
                end
                DASQ_ADC_STOP: begin
                    if (converter_clock) begin
                        adc_cnt <= adc_cnt + 3'h1;
                        if (adc_cnt == 3'(`DASQ_STOP_MAX_CYC - 1)) begin
                            adc_state <= DASQ_ADC_IDLE;
                        end
                    end
                end
                default: begin
                    adc_state <= DASQ_ADC_IDLE;
                    adc_cnt <= 3'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Output amplifier sequencing. Armed only when switch and enable are set
    // with the converter off and a zero preload; any drop of both enables
    // returns it to off so the full sequence must be repeated.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amp_state <= DASQ_AMP_OFF;
            settle_cnt <= 16'h0000;
        end else begin
            case (amp_state)
                DASQ_AMP_OFF: begin
                    settle_cnt <= 16'h0000;
                    if (chan0_amp_switch && chan0_amp_enable && !out_req && !chan0_converter_enable &&
                        chan0_data_preload == `DASQ_DATA_RESET && !event_link_drive) begin
                        amp_state <= DASQ_AMP_ARMED;
                    end
                end
                DASQ_AMP_ARMED: begin
                    if (!chan0_amp_enable || !chan0_amp_switch || event_link_drive) begin
                        amp_state <= DASQ_AMP_OFF;
                    end else if (out_req) begin
                        amp_state <= DASQ_AMP_SETTLE;
                    end
                end
                DASQ_AMP_SETTLE: begin
                    if (!out_req || !chan0_amp_enable) begin
                        amp_state <= DASQ_AMP_OFF;
                    end else if (settle_cnt != 16'(`DASQ_AMP_SETTLE_CYC)) begin
                        settle_cnt <= settle_cnt + 16'h0001;
                    end else if (!chan0_amp_switch) begin
                        amp_state <= DASQ_AMP_ON;
                    end
                end
                DASQ_AMP_ON: begin
                    if (!out_req || !chan0_amp_enable) begin
                        amp_state <= DASQ_AMP_OFF;
                    end
                end
                default: begin
                    amp_state <= DASQ_AMP_OFF;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Registered outputs toward the analog macros
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_analog_run_o <= 1'b0;
            amp_on_o <= 1'b0;
            amp_switch_o <= 1'b0;
            dac_out_en_o <= 1'b0;
            dac_value_o <= `DASQ_DATA_RESET;
        end else begin
            adc_analog_run_o <= (adc_state == DASQ_ADC_RUN) || (adc_state == DASQ_ADC_STOP);
            amp_on_o <= (amp_state == DASQ_AMP_SETTLE) || (amp_state == DASQ_AMP_ON);
            amp_switch_o <= chan0_amp_switch;
            dac_out_en_o <= out_req && !dac_halted;
            dac_value_o <= (amp_state == DASQ_AMP_ON) ? chan0_conversion_value : chan0_data_preload;
        end
    end

    // ------------------------------------------------------------------------
    // Read data, registered with the acknowledge; unmapped reads give zero
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                `DASQ_ADC_CONTROL_STATUS_OFS: begin
                    wb_dat_o <= {30'h0, adc_state == DASQ_ADC_RUN, conversion_start_bit};
                end
                `DASQ_INTERFERENCE_GUARD_CONTROL_OFS: begin
                    wb_dat_o <= {31'h0, interference_guard_enable};
                end
                `DASQ_DAC_CONTROL_OFS: begin
                    wb_dat_o <= {27'h0, amp_state == DASQ_AMP_ON, amp_on_o, chan0_output_enable,
                                 chan0_converter_enable, shared_converter_enable};
                end
                `DASQ_AMP_SWITCH_CONTROL_OFS: begin
                    wb_dat_o <= {30'h0, chan0_amp_enable, chan0_amp_switch};
                end
                `DASQ_CHAN0_DATA_PRELOAD_OFS: begin
                    wb_dat_o <= {20'h00000, chan0_data_preload};
                end
                `DASQ_CHAN0_CONVERSION_VALUE_OFS: begin
                    wb_dat_o <= {20'h00000, chan0_conversion_value};
                end
                `DASQ_CONVERTER_CLOCK_DIV_OFS: begin
                    wb_dat_o <= {24'h000000, clk_div};
                end
                `DASQ_MODULE_CONTROL_OFS: begin
                    wb_dat_o <= {29'h0, dac_halted, event_link_drive, adc1_module_stop};
                end
                default: begin
                    wb_dat_o <= 32'h00000000;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// ===== rtl/dasq_consts.svh
// Constants for the converter sequencing block: register offsets, field positions, reset values, timing.
// Assumes a 100 MHz system clock and a Wishbone slave with a 32-bit data path.
`ifndef DASQ_CONSTS_SVH
`define DASQ_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define DASQ_ADC_CONTROL_STATUS_OFS 8'h00
`define DASQ_INTERFERENCE_GUARD_CONTROL_OFS 8'h04
`define DASQ_DAC_CONTROL_OFS 8'h08
`define DASQ_AMP_SWITCH_CONTROL_OFS 8'h0c
`define DASQ_CHAN0_DATA_PRELOAD_OFS 8'h10
`define DASQ_CHAN0_CONVERSION_VALUE_OFS 8'h14
`define DASQ_CONVERTER_CLOCK_DIV_OFS 8'h18
`define DASQ_MODULE_CONTROL_OFS 8'h1c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DASQ_CONV_START_BIT 0
`define DASQ_ADC_RUNNING_BIT 1
`define DASQ_GUARD_ENABLE_BIT 0
`define DASQ_SHARED_ENABLE_BIT 0
`define DASQ_CHAN0_ENABLE_BIT 1
`define DASQ_CHAN0_OUT_ENABLE_BIT 2
`define DASQ_AMP_ACTIVE_BIT 3
`define DASQ_AMP_READY_BIT 4
`define DASQ_CHAN0_AMP_SWITCH_BIT 0
`define DASQ_CHAN0_AMP_ENABLE_BIT 1
`define DASQ_ADC1_STOP_BIT 0
`define DASQ_EVENT_LINK_BIT 1
`define DASQ_DAC_HALTED_BIT 2

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define DASQ_DATA_RESET 12'h000
`define DASQ_DIV_RESET 8'h03
`define DASQ_CLK_MHZ 100
`define DASQ_RESTART_MAX_CYC 6
`define DASQ_STOP_MAX_CYC 2
`define DASQ_AMP_SETTLE_US 3
`define DASQ_AMP_SETTLE_CYC (`DASQ_AMP_SETTLE_US * `DASQ_CLK_MHZ)

`endif

// ===== rtl/dasq_pkg.sv
// Types for the converter sequencing block.
// Assumes nothing beyond the constants header.
`default_nettype none

package dasq_pkg;
    // ------------------------------------------------------------------------
    // Analog unit state of the A/D, Gray along idle-start-run-stop
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        DASQ_ADC_IDLE = 2'b00,
        DASQ_ADC_START = 2'b01,
        DASQ_ADC_RUN = 2'b11,
        DASQ_ADC_STOP = 2'b10
    } dasq_adc_e;

    // ------------------------------------------------------------------------
    // Output amplifier state, Gray along off-armed-settle-on
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        DASQ_AMP_OFF = 2'b00,
        DASQ_AMP_ARMED = 2'b01,
        DASQ_AMP_SETTLE = 2'b11,
        DASQ_AMP_ON = 2'b10
    } dasq_amp_e;
endpackage

`default_nettype wire

// ===== dv/dasq_top_assertions.sv
// ----------------------------------------------------------------------------
// Checker for the converter sequencing block
// ----------------------------------------------------------------------------
// Sees only the top ports; bounds assume a converter clock divider of 3 or less.
`include "dasq_consts.svh"
`default_nettype none

module dasq_top_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic adc_analog_run_o,
    input wire logic amp_on_o,
    input wire logic amp_switch_o,
    input wire logic dac_out_en_o,
    input wire logic [11:0] dac_value_o
);
    // Request accepted at this edge
    logic taken;
    // Write to the amplifier switch register, kept as a signal so $past can see it
    logic sw_wr;
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign sw_wr = taken && wb_we_i && wb_sel_i[0] && (wb_adr_i == `DASQ_AMP_SWITCH_CONTROL_OFS);

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Accepted write of the low byte lane to one register
    sequence wr_s(ofs);
        taken && wb_we_i && wb_sel_i[0] && (wb_adr_i == ofs);
    endsequence

    ack_follow_a: assert property (taken |=> wb_ack_o) else $error("ack missing after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    // Six pulses of at most four clocks each, plus pipeline slack
    adc_restart_a: assert property (wr_s(`DASQ_ADC_CONTROL_STATUS_OFS) ##0 (wb_dat_i[0] && !adc_analog_run_o)
        |-> ##[1:30] adc_analog_run_o) else $error("A/D did not restart in time");
    adc_stop_a: assert property (wr_s(`DASQ_ADC_CONTROL_STATUS_OFS) ##0 (!wb_dat_i[0] && adc_analog_run_o)
        |-> ##[1:12] !adc_analog_run_o) else $error("A/D did not stop in time");
    amp_needs_oe_a: assert property ($rose(amp_on_o) |-> ##[0:2] dac_out_en_o)
        else $error("amplifier started without output enable");
    amp_off_a: assert property (wr_s(`DASQ_DAC_CONTROL_OFS) ##0 (!wb_dat_i[0] && !wb_dat_i[2])
        |-> ##[1:3] !amp_on_o) else $error("amplifier stayed on after enables cleared");
    switch_hold_a: assert property ($changed(amp_switch_o) |-> $past(sw_wr) || $past(sw_wr, 2))
        else $error("amplifier switch changed without a write");
    amp_seen_c: cover property (amp_on_o && !amp_switch_o);
endmodule

bind dasq_top dasq_top_assertions dasq_top_assertions_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_analog_run_o(adc_analog_run_o), .amp_on_o(amp_on_o),
    .amp_switch_o(amp_switch_o), .dac_out_en_o(dac_out_en_o), .dac_value_o(dac_value_o));

`default_nettype wire

// ===== dv/testbench.sv
// ----------------------------------------------------------------------------
// Self-checking bench for the converter sequencing block
// ----------------------------------------------------------------------------
// Drives the Wishbone port directly; the checker is attached by bind.
`include "dasq_consts.svh"
`default_nettype none

// Compare and count; case inequality so unknowns never match
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); end end

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] a_adc = `DASQ_ADC_CONTROL_STATUS_OFS;
    localparam logic [7:0] a_grd = `DASQ_INTERFERENCE_GUARD_CONTROL_OFS;
    localparam logic [7:0] a_dac = `DASQ_DAC_CONTROL_OFS;
    localparam logic [7:0] a_sw = `DASQ_AMP_SWITCH_CONTROL_OFS;
    localparam logic [7:0] a_mod = `DASQ_MODULE_CONTROL_OFS;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, adc_analog_run_o, amp_on_o, amp_switch_o, dac_out_en_o;
    logic [11:0] dac_value_o;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n, div;
    logic [31:0] lfsr = 32'h9120;
    logic [31:0] rd;
    logic [31:0] oe_bits [2] = '{32'h4, 32'h1};

    dasq_top dasq_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .adc_analog_run_o(adc_analog_run_o), .amp_on_o(amp_on_o),
        .amp_switch_o(amp_switch_o), .dac_out_en_o(dac_out_en_o), .dac_value_o(dac_value_o));

    // 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // Next random word; Galois-free taps keep it simple and repeatable
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Single classic cycle; holds everything until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Count edges until A/D run (sel 0) or amplifier power (sel 1) reaches val; bounded
    task automatic wait_out(input logic sel, input logic val, output int cnt);
        cnt = 0;
        while (((sel ? amp_on_o : adc_analog_run_o) !== val) && cnt < 400) begin
            @(posedge clk_i);
            cnt++;
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs about a thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            $display("MISMATCH t=%0t timeout", $time);
            print_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values and an unmapped read
        wb_xfer(1'b0, `DASQ_CONVERTER_CLOCK_DIV_OFS, 32'h0, rd);
        `CHK(rd, 32'h3)
        wb_xfer(1'b0, 8'h40, 32'h0, rd);
        `CHK(rd, 32'h0)
        `CHK({adc_analog_run_o, amp_on_o, amp_switch_o, dac_out_en_o}, 4'h0)
        // A/D start and stop latency with a random divider
        for (int k = 0; k < 3; k++) begin
            lfsr = lfsr_next(lfsr);
            div = int'(lfsr[1:0]);
            wb_xfer(1'b1, `DASQ_CONVERTER_CLOCK_DIV_OFS, 32'(div), rd);
            wb_xfer(1'b1, a_adc, 32'h1, rd);
            wait_out(1'b0, 1'b1, n);
            `CHK(n <= `DASQ_RESTART_MAX_CYC * (div + 1) + 3, 1'b1)
            wb_xfer(1'b0, a_adc, 32'h0, rd);
            `CHK(rd[1:0], 2'b11)
            wb_xfer(1'b1, a_adc, 32'h0, rd);
            wait_out(1'b0, 1'b0, n);
            `CHK(n <= `DASQ_STOP_MAX_CYC * (div + 1) + 3, 1'b1)
        end
        // Full amplifier sequence, once per output enable choice
        foreach (oe_bits[i]) begin
            wb_xfer(1'b0, a_dac, 32'h0, rd);
            `CHK(rd[1:0], 2'b00)
            wb_xfer(1'b1, `DASQ_CHAN0_DATA_PRELOAD_OFS, 32'h0, rd);
            wb_xfer(1'b1, a_sw, 32'h1, rd);
            wb_xfer(1'b1, a_sw, 32'h3, rd);
            wb_xfer(1'b1, a_dac, oe_bits[i], rd);
            wait_out(1'b1, 1'b1, n);
            `CHK({amp_on_o, dac_out_en_o, dac_value_o}, 14'h3000)
            repeat (310) @(posedge clk_i);
            `CHK(amp_switch_o, 1'b1)
            lfsr = lfsr_next(lfsr);
            wb_xfer(1'b1, a_sw, 32'h2, rd);
            wb_xfer(1'b1, `DASQ_CHAN0_CONVERSION_VALUE_OFS, {20'h0, lfsr[11:0]}, rd);
            repeat (3) @(posedge clk_i);
            `CHK({amp_switch_o, dac_value_o}, {1'b0, lfsr[11:0]})
            wb_xfer(1'b0, a_dac, 32'h0, rd);
            `CHK(rd[4:3], 2'b11)
            wb_xfer(1'b1, a_dac, 32'h0, rd);
            wait_out(1'b1, 1'b0, n);
            `CHK(n < 4, 1'b1)
            wb_xfer(1'b1, a_dac, oe_bits[i], rd);
            repeat (4) @(posedge clk_i);
            `CHK(amp_on_o, 1'b0)
            wb_xfer(1'b1, a_dac, 32'h0, rd);
        end
        // Converter enable already set keeps the amplifier from arming
        wb_xfer(1'b1, a_dac, 32'h2, rd);
        wb_xfer(1'b1, a_sw, 32'h3, rd);
        wb_xfer(1'b1, a_dac, 32'h6, rd);
        repeat (4) @(posedge clk_i);
        `CHK(amp_on_o, 1'b0)
        wb_xfer(1'b1, a_sw, 32'h0, rd);
        wb_xfer(1'b1, a_dac, 32'h0, rd);
        // Event link driving the converter blocks arming
        wb_xfer(1'b1, a_mod, 32'h2, rd);
        wb_xfer(1'b1, a_sw, 32'h3, rd);
        wb_xfer(1'b1, a_dac, 32'h4, rd);
        repeat (4) @(posedge clk_i);
        `CHK(amp_on_o, 1'b0)
        wb_xfer(1'b1, a_mod, 32'h0, rd);
        // Unit 1 stop under the guard halts the output; a halted-bit write clears it once the guard is off
        wb_xfer(1'b1, a_grd, 32'h1, rd);
        wb_xfer(1'b1, a_mod, 32'h1, rd);
        repeat (3) @(posedge clk_i);
        `CHK(dac_out_en_o, 1'b0)
        wb_xfer(1'b1, a_grd, 32'h0, rd);
        wb_xfer(1'b1, a_mod, 32'h4, rd);
        wb_xfer(1'b0, a_mod, 32'h0, rd);
        `CHK(rd[2], 1'b0)
        print_verdict();
    end
endmodule

`default_nettype wire
